// *** design/lir_legacy_router.sv ***
// legacy interrupt routing: source map, cascaded controllers, serialized link
`timescale 1ns/1ps
module lir_legacy_router #(
	parameter int unsigned NUM_CHANNELS = lir_pkg::LIR_MIN_CHANNELS
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_i,
	// sources and configuration
	input wire logic [lir_pkg::LIR_NUM_SOURCES-1:0] source_req_i,
	input wire logic [lir_pkg::LIR_NUM_SOURCES*4-1:0] source_map_i,
	input wire logic serial_swap_i,
	input wire logic serial_a_req_i,
	input wire logic serial_b_req_i,
	input wire logic primary_disk_request_line_i,
	input wire logic rtc_request_active_low_i,
	input wire lir_pkg::lir_cfg_t cfg_i,
	// processor side
	input wire logic inta_i,
	output logic processor_interrupt_request_o,
	output logic [3:0] vector_level_o,
	// management
	input wire logic hub_smi_i,
	input wire logic mgmt_smi_i,
	input wire logic sleep_req_i,
	input wire logic sys_event_i,
	output logic system_management_interrupt_o,
	output logic system_control_interrupt_o,
	// serialized link (open drain, three signals)
	input wire lir_pkg::lir_link_cfg_t link_cfg_i,
	input wire logic serialized_interrupt_link_i,
	output logic serialized_interrupt_link_o,
	output logic serialized_interrupt_link_oe_o
);
	import lir_pkg::*;

	initial begin
		if (NUM_CHANNELS < LIR_MIN_CHANNELS || NUM_CHANNELS > 32)
			$error("NUM_CHANNELS must be 17..32");
	end

	typedef enum {ST_IDLE, ST_START, ST_CHAN, ST_STOP} lir_state_t;

	// ----------------------------------------------------------------
	// source mapping
	// ----------------------------------------------------------------
	logic [15:0] mapped;
	logic [15:0] level_raw;
	logic [15:0] serial_bits;
	logic [15:0] link_req;
	genvar g;
	generate
		for (g = 0; g < LIR_NUM_SOURCES; g++) begin : g_map
			// a source counts only while it is both raised and routed somewhere
			assign mapped[g] = source_req_i[g] && (source_map_i[g*4 +: 4] != LIR_UNROUTED);
		end
	endgenerate

	function automatic logic [15:0] lir_decode(input logic [3:0] lvl, input logic req);
		lir_decode = (req && lvl != LIR_UNROUTED) ? (16'h0001 << lvl) : 16'h0000;
	endfunction

	logic [15:0] routed;
	always_comb begin
		routed = 16'h0000;
		for (int i = 0; i < LIR_NUM_SOURCES; i++)
			routed = routed | lir_decode(source_map_i[i*4 +: 4], mapped[i]);
	end

	// serial ports on 3/4, swap selects which port owns which level
	assign serial_bits = (16'h0001 << LIR_SERIAL_LOW_LEVEL) & {16{serial_swap_i ? serial_b_req_i
		: serial_a_req_i}} | (16'h0001 << LIR_SERIAL_HIGH_LEVEL) & {16{serial_swap_i
		? serial_a_req_i : serial_b_req_i}};
	assign level_raw = routed | serial_bits | link_req
		| ({15'h0000, primary_disk_request_line_i} << LIR_DISK_LEVEL)
		| ({15'h0000, ~rtc_request_active_low_i} << LIR_RTC_LEVEL);

	// ----------------------------------------------------------------
	// cascaded controllers
	// ----------------------------------------------------------------
	logic [15:0] level_in;
	logic [15:0] pending;
	logic [15:0] in_service;
	logic [7:0] sec_active;
	logic [7:0] pri_active;
	logic [3:0] winner;
	logic winner_valid;
	assign level_in = (level_raw ^ cfg_i.active_low) & ~cfg_i.level_mask;
	assign sec_active = pending[15:8] & ~in_service[15:8];
	assign pri_active = {pending[7:3], |sec_active, pending[1:0]}
		& ~{in_service[7:3], |in_service[15:8], in_service[1:0]};

	always_comb begin
		winner = 4'h0;
		winner_valid = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			if (pri_active[i]) begin
				winner_valid = 1'b1;
				winner = 4'(i);
			end
		end
		if (winner_valid && winner == 4'(LIR_CASCADE_LEVEL)) begin
			for (int j = 7; j >= 0; j--) begin
				if (sec_active[j])
					winner = 4'(j + 8);
			end
		end
	end

	// acknowledge latches winner into service; one inta per request
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			pending <= 16'h0000;
			in_service <= 16'h0000;
			vector_level_o <= 4'h0;
		end else begin
			// level sensitive: a dropped line must not leave a stale request behind
			pending <= level_in;
			if (inta_i && winner_valid) begin
				in_service <= in_service | (16'h0001 << winner);
				vector_level_o <= winner;
			end else if (!(|level_in)) begin
				in_service <= 16'h0000;
			end
		end
	end
	assign processor_interrupt_request_o = winner_valid;

	// ----------------------------------------------------------------
	// management interrupts
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			system_management_interrupt_o <= 1'b0;
			system_control_interrupt_o <= 1'b0;
		end else begin
			system_management_interrupt_o <= hub_smi_i | mgmt_smi_i;
			system_control_interrupt_o <= sleep_req_i | sys_event_i;
		end
	end

	// ----------------------------------------------------------------
	// serialized link host
	// ----------------------------------------------------------------
	lir_state_t state;
	lir_state_t next_state;
	logic [5:0] count;
	logic [5:0] next_count;
	logic link_low;
	logic [15:0] sampled;
	assign link_low = link_cfg_i.enable && !serialized_interrupt_link_i;

	always_comb begin
		next_state = state;
		next_count = count + 6'h01;
		case (state)
			ST_IDLE: begin
				// a slave's start is seen one clock late: that clock is start clock 0
				next_count = (link_low && !link_cfg_i.continuous) ? 6'h01 : 6'h00;
				if (link_cfg_i.enable && (link_cfg_i.continuous || link_low))
					next_state = ST_START;
			end
			ST_START: if (count == 6'(LIR_START_CLOCKS - 1)) begin
				next_state = ST_CHAN;
				next_count = 6'h00;
			end
			ST_CHAN: if (count == 6'(NUM_CHANNELS - 1)) begin
				next_state = ST_STOP;
				next_count = 6'h00;
			end
			ST_STOP: if (count == 6'(LIR_STOP_CLOCKS - 1))
				next_state = ST_IDLE;
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			state <= ST_IDLE;
			count <= 6'h00;
			sampled <= 16'h0000;
			link_req <= 16'h0000;
		end else begin
			state <= next_state;
			count <= next_count;
			if (state == ST_CHAN && count < 6'(LIR_NUM_LEVELS))
				sampled[count[3:0]] <= !serialized_interrupt_link_i;
			if (state == ST_STOP && count == 6'h00)
				link_req <= sampled;
		end
	end

	// host drives start low in continuous mode only; stop driven by host too
	assign serialized_interrupt_link_o = 1'b0;
	assign serialized_interrupt_link_oe_o = (state == ST_START && link_cfg_i.continuous)
		|| state == ST_STOP;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	cascade_win_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(winner_valid && winner >= 4'h8) |-> pri_active[LIR_CASCADE_LEVEL])
		else $error("secondary win without cascade level");
	irq_out_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		processor_interrupt_request_o == (|pri_active))
		else $error("interrupt output disagrees with primary");
	smi_path_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(hub_smi_i || mgmt_smi_i) |=> system_management_interrupt_o)
		else $error("management interrupt not raised");
	sci_path_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		sleep_req_i |=> system_control_interrupt_o)
		else $error("control interrupt not raised");
	frame_len_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(state == ST_START && count == 6'h01) |-> ##3 state == ST_CHAN
		##(NUM_CHANNELS) state == ST_STOP)
		else $error("serialized frame length wrong");
	quiet_start_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(state == ST_IDLE && link_cfg_i.enable && link_low) |=> state == ST_START)
		else $error("slave start not followed");
	host_start_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(state == ST_START && !link_cfg_i.continuous) |-> !serialized_interrupt_link_oe_o)
		else $error("host drove start in quiet mode");
	rtc_low_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(!rtc_request_active_low_i && !cfg_i.level_mask[LIR_RTC_LEVEL]
		&& !cfg_i.active_low[LIR_RTC_LEVEL]) |=> pending[LIR_RTC_LEVEL])
		else $error("rtc low not pending");
	cv_cascade: cover property (@(posedge ref_clk_i) winner_valid && winner >= 4'h8);
	cv_ack: cover property (@(posedge ref_clk_i) inta_i && winner_valid);
	cv_frame: cover property (@(posedge ref_clk_i) state == ST_STOP);
endmodule // lir_legacy_router

// *** design/lir_pkg.sv ***
// package for legacy interrupt routing: constants and carrier types
package lir_pkg;
	localparam int unsigned LIR_NUM_LEVELS = 16;
	localparam int unsigned LIR_CASCADE_LEVEL = 2;
	localparam int unsigned LIR_RTC_LEVEL = 8;
	localparam int unsigned LIR_SERIAL_LOW_LEVEL = 3;
	localparam int unsigned LIR_SERIAL_HIGH_LEVEL = 4;
	localparam int unsigned LIR_DISK_LEVEL = 14;
	localparam int unsigned LIR_MIN_CHANNELS = 17;
	localparam int unsigned LIR_NUM_SOURCES = 16;
	localparam int unsigned LIR_START_CLOCKS = 4;
	localparam int unsigned LIR_STOP_CLOCKS = 2;
	localparam logic [15:0] LIR_RESET_MASK = 16'hffff;
	// map value 4'h0 means unrouted; level 0 is driven only by the serialized link in this block
	localparam logic [3:0] LIR_UNROUTED = 4'h0;

	typedef struct packed {
		logic [15:0] level_mask;
		logic [15:0] active_low;
	} lir_cfg_t;

	typedef struct packed {
		logic continuous;
		logic enable;
	} lir_link_cfg_t;
endpackage

// *** bench/lir_serial_slave.sv ***
// serialized link slave model: answers one channel slot
`timescale 1ns/1ps
module lir_serial_slave #(
	parameter int unsigned NUM_CHANNELS = 17
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_i,
	// link and request
	input wire logic wire_i,
	input wire logic req_i,
	input wire logic start_i,
	input wire logic [3:0] chan_i,
	output logic drive_o
);
	import lir_pkg::*;
	int low_run;
	int slot;
	// slot numbering restarts on the last low clock of a start frame
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			low_run <= 0;
			slot <= 63;
		end else begin
			low_run <= wire_i ? 0 : low_run + 1;
			if (!wire_i && low_run == LIR_START_CLOCKS - 1) begin
				slot <= 0;
			end else if (slot < 63) begin
				slot <= slot + 1;
			end
		end
	end
	// open drain: only ever pulls low, in its own slot or while start_i is high
	assign drive_o = start_i || (req_i && slot == int'(chan_i) && slot < NUM_CHANNELS);
endmodule // lir_serial_slave

// *** bench/lir_legacy_router_tb_top.sv ***
// self-checking testbench for legacy interrupt routing
`timescale 1ns/1ps
module lir_legacy_router_tb_top;
	import lir_pkg::*;
	logic ref_clk_i = 0, reset_i = 1, serial_swap_i = 0, serial_a_req_i = 0;
	logic serial_b_req_i = 0, primary_disk_request_line_i = 0, inta_i = 0;
	logic rtc_request_active_low_i = 1, preq = 0, pstart = 0;
	logic [3:0] mgmt = 0;
	logic [15:0] source_req_i = 0;
	logic [63:0] source_map_i = 0;
	lir_cfg_t cfg_i = '0;
	lir_link_cfg_t link_cfg_i = '0;
	wire irq, system_management_interrupt, system_control_interrupt, lo, oe, pdrv;
	wire [3:0] vec;
	wire lnk = ~(oe | pdrv); // pulled up
	int fails = 0, compares = 0, seed = 79182, lvl, src, n;
	lir_legacy_router u_lir_legacy_router (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
		.source_req_i(source_req_i), .source_map_i(source_map_i),
		.serial_swap_i(serial_swap_i), .serial_a_req_i(serial_a_req_i),
		.serial_b_req_i(serial_b_req_i),
		.primary_disk_request_line_i(primary_disk_request_line_i),
		.rtc_request_active_low_i(rtc_request_active_low_i), .cfg_i(cfg_i),
		.inta_i(inta_i), .processor_interrupt_request_o(irq), .vector_level_o(vec),
		.hub_smi_i(mgmt[0]), .mgmt_smi_i(mgmt[1]), .sleep_req_i(mgmt[2]),
		.sys_event_i(mgmt[3]), .system_management_interrupt_o(system_management_interrupt),
		.system_control_interrupt_o(system_control_interrupt), .link_cfg_i(link_cfg_i),
		.serialized_interrupt_link_i(lnk), .serialized_interrupt_link_o(lo),
		.serialized_interrupt_link_oe_o(oe));
	lir_serial_slave u_lir_serial_slave (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
		.wire_i(lnk), .req_i(preq), .start_i(pstart), .chan_i(4'h5), .drive_o(pdrv));
	initial begin
		forever #10 ref_clk_i = ~ref_clk_i;
	end
	task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task tick(input int k);
		repeat (k) @(posedge ref_clk_i);
		#1;
	endtask
	// one responder: a single acknowledge pulse per request
	task svc(input int exp);
		tick(2);
		chk("request", {7'h0, irq}, 8'h01);
		inta_i = 1;
		tick(1);
		inta_i = 0;
		tick(1);
		chk("vector", {4'h0, vec}, exp[7:0]);
	endtask
	task run(input int k);
		n = 0;
		while (oe === k[0] && n < 99) begin
			n++;
			tick(1);
		end
	endtask
	task stop_test;
		if (fails == 0 && compares > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial begin
		#200000;
		fails++;
		stop_test;
	end
	initial begin
		tick(4);
		reset_i = 0;
		chk("idle request", {7'h0, irq}, 8'h00);
		serial_a_req_i = 1;
		svc(LIR_SERIAL_LOW_LEVEL);
		serial_a_req_i = 0;
		serial_swap_i = 1;
		tick(3);
		serial_a_req_i = 1;
		svc(LIR_SERIAL_HIGH_LEVEL);
		serial_a_req_i = 0;
		tick(3);
		rtc_request_active_low_i = 0;
		svc(LIR_RTC_LEVEL);
		rtc_request_active_low_i = 1;
		tick(3);
		primary_disk_request_line_i = 1;
		svc(LIR_DISK_LEVEL);
		primary_disk_request_line_i = 0;
		for (int i = 0; i < 6; i++) begin
			tick(3);
			src = {$random(seed)} % 16;
			lvl = 3 + {$random(seed)} % 13;
			source_map_i[src*4+:4] = lvl[3:0];
			source_req_i[src] = 1;
			svc(lvl);
			source_req_i = 0;
			source_map_i = 0;
		end
		for (int i = 0; i < 4; i++) begin
			mgmt = 4'h1 << i;
			tick(2);
			chk("smi", {7'h0, system_management_interrupt}, {7'h0, i < 2});
			chk("sci", {7'h0, system_control_interrupt}, {7'h0, i > 1});
			mgmt = 0;
		end
		tick(3);
		preq = 1;
		link_cfg_i = '{continuous: 1'b1, enable: 1'b1};
		run(0);
		run(1);
		chk("start clocks", n[7:0], 8'(LIR_START_CLOCKS));
		run(0);
		chk("channel clocks", n[7:0], 8'(LIR_MIN_CHANNELS));
		run(1);
		chk("stop clocks", n[7:0], 8'(LIR_STOP_CLOCKS));
		svc(5);
		preq = 0;
		link_cfg_i = '{continuous: 1'b0, enable: 1'b1};
		tick(40);
		chk("quiet idle request", {7'h0, irq}, 8'h00);
		chk("link level", {7'h0, lo}, 8'h00);
		preq = 1;
		pstart = 1;
		tick(4);
		pstart = 0;
		chk("quiet host drive", {7'h0, oe}, 8'h00);
		tick(22);
		svc(5);
		stop_test;
	end
endmodule // lir_legacy_router_tb_top
